// [rtl/fub_top.sv]
module fub_fifo
    import fub_pkg::*;
#(
    parameter int W = 10,
    parameter int D = 32
)(
    input  wire logic         clk,       // Clock
    input  wire logic         arst_n,    // Async reset
    input  wire logic         ce,        // Clock enable
    input  wire logic         in_valid,  // Write valid
    output      logic         in_ready,  // Not full
    input  wire logic [W-1:0] in_data,   // Write word
    output      logic         out_valid, // Not empty
    input  wire logic         out_ready, // Read accept
    output      logic [W-1:0] out_data   // Head word
);
    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } fub_fifo_s;

    fub_fifo_s      r;
    fub_fifo_s      next_r;
    logic [W-1:0]   store [D];
    logic           push;
    logic           pop;

    assign in_ready  = r.cnt < (AW+1)'(D);
    assign out_valid = r.cnt != '0;
    assign out_data  = store[r.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb
    begin
        next_r = r;
        if (push)
        begin
            next_r.wp = (r.wp == AW'(D-1)) ? '0 : r.wp + 1'b1;
        end
        if (pop)
        begin
            next_r.rp = (r.rp == AW'(D-1)) ? '0 : r.rp + 1'b1;
        end
        next_r.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            r <= '0;
        end
        else if (ce)
        begin
            r <= next_r;
        end
    end

    always_ff @(posedge clk)
    begin
        if (ce && push)
        begin
            store[r.wp] <= in_data;
        end
    end
endmodule : fub_fifo

module fub_top
    import fub_pkg::*;
#(
    parameter int          APP_AW       = 8,
    parameter int          FIFO_DEPTH   = 32,
    parameter logic [87:0] PRODUCT_CODE = 88'h3031323334353637383941  // Arbitrary value
)(
    input  wire logic       CLOCK,        // 20 MHz clock
    input  wire logic       ARST_N,       // Async reset
    input  wire logic       CE,           // Clock enable
    input  wire logic       IN_VALID,     // Write byte valid
    output      logic       IN_READY,     // Write byte accepted
    input  wire logic [7:0] IN_DATA,      // Write byte
    input  wire logic       IN_FIRST,     // Byte is command code
    input  wire logic       IN_LAST,      // Last byte of write
    input  wire logic       RD_VALID,     // Read request
    output      logic       RD_READY,     // Read request taken
    input  wire logic [7:0] RD_CMD,       // Command being read
    output      logic       OUT_VALID,    // Response byte valid
    input  wire logic       OUT_READY,    // Response byte taken
    output      logic [7:0] OUT_DATA,     // Response byte
    output      logic       OUT_LAST,     // Last response byte
    output      logic       MAIN_OUT_OFF, // Force main output off
    output      logic       APP_RUN,      // Application running
    output      logic       UNLOCKED      // Upgrade commands enabled
);
    localparam int MW = APP_AW + 2;

    typedef enum logic [4:0] {
        S_IDLE  = 5'h01,
        S_ARGS  = 5'h02,
        S_ERASE = 5'h04,
        S_CRC   = 5'h08,
        S_SEND  = 5'h10
    } fub_state_e;

    typedef struct packed {
        fub_state_e                       st;
        logic                             unlocked;
        logic                             in_boot;
        logic [7:0]                       cmd;
        logic [3:0]                       idx;
        logic [1:0]                       tgt;
        logic [1:0]                       rtgt;
        logic [7:0]                       arg0;
        logic [31:0]                      pw;
        logic                             pkt_bad;
        logic [NUM_TGT-1:0][7:0]          stat;
        logic [NUM_TGT-1:0][15:0]         seq;
        logic [NUM_TGT-1:0][APP_AW:0]     len;
        logic [APP_AW-1:0]                walk;
        logic [15:0]                      crc;
        logic [RSP_MAX-1:0][7:0]          rsp;
        logic [3:0]                       rlen;
        logic [3:0]                       ridx;
    } fub_st_s;

    fub_st_s     r;
    fub_st_s     next_r;
    logic [7:0]  app_mem [2**MW];
    logic        f_valid;
    logic        f_pop;
    logic [9:0]  f_data;
    logic        mem_we;
    logic [MW-1:0] mem_a;
    logic [7:0]  mem_d;
    logic [7:0]  walk_rd;
    logic [15:0] crc_exp;
    logic [15:0] crc_new;

    function automatic logic [1:0] fub_tidx(input logic [7:0] c);
        unique case (c)
            TGT_P:   fub_tidx = 2'h0;
            TGT_S:   fub_tidx = 2'h1;
            TGT_I:   fub_tidx = 2'h2;
            default: fub_tidx = TGT_NONE;
        endcase
    endfunction : fub_tidx

    function automatic logic [15:0] fub_crc(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] v;
        v = c ^ {b, 8'h00};
        for (int i = 0; i < 8; i++)
        begin
            v = v[15] ? ((v << 1) ^ CRC_POLY) : (v << 1);
        end
        fub_crc = v;
    endfunction : fub_crc

    fub_fifo #(
        .W (10),
        .D (FIFO_DEPTH)
    ) u_fifo (
        .clk       (CLOCK),
        .arst_n    (ARST_N),
        .ce        (CE),
        .in_valid  (IN_VALID),
        .in_ready  (IN_READY),
        .in_data   ({IN_LAST, IN_FIRST, IN_DATA}),
        .out_valid (f_valid),
        .out_ready (f_pop),
        .out_data  (f_data)
    );

    assign walk_rd      = app_mem[{r.tgt, r.walk}];
    assign crc_exp      = {app_mem[{r.tgt, APP_AW'(r.len[r.tgt] - 2'd2)}],
                           app_mem[{r.tgt, APP_AW'(r.len[r.tgt] - 1'b1)}]};
    assign crc_new      = fub_crc(r.crc, walk_rd);
    assign OUT_VALID    = r.st == S_SEND;
    assign OUT_DATA     = r.rsp[0];
    assign OUT_LAST     = r.ridx == r.rlen - 1'b1;
    assign MAIN_OUT_OFF = r.in_boot;
    assign APP_RUN      = !r.in_boot;
    assign UNLOCKED     = r.unlocked;

    always_comb
    begin
        logic [7:0] b;
        logic [1:0] t;
        logic       ok;
        b        = f_data[7:0];
        t        = fub_tidx(r.arg0);
        ok       = 1'b1;
        next_r   = r;
        f_pop    = 1'b0;
        RD_READY = 1'b0;
        mem_we   = 1'b0;
        mem_a    = '0;
        mem_d    = '0;
        unique case (r.st)
            S_IDLE:
            begin
                if (f_valid)
                begin
                    // Stray non-command bytes are dropped
                    f_pop = 1'b1;
                    if (f_data[8])
                    begin
                        next_r.cmd     = b;
                        next_r.idx     = '0;
                        next_r.pkt_bad = 1'b0;
                        if (!f_data[9])
                        begin
                            next_r.st = S_ARGS;
                        end
                    end
                end
                else if (RD_VALID)
                begin
                    RD_READY    = 1'b1;
                    next_r.st   = S_SEND;
                    next_r.ridx = '0;
                    next_r.rsp  = '0;
                    unique case (RD_CMD)
                        CMD_DATA:
                        begin
                            next_r.rsp[0] = SEQ_RSP_CNT;
                            next_r.rsp[1] = r.seq[r.tgt][7:0];
                            next_r.rsp[2] = r.seq[r.tgt][15:8];
                            next_r.rsp[3] = r.stat[r.tgt];
                            next_r.rlen   = 4'h4;
                        end
                        CMD_APPSTAT:
                        begin
                            next_r.rsp[0] = (r.rtgt == TGT_NONE) ? ST_AVAIL : r.stat[r.rtgt];
                            next_r.rlen   = 4'h1;
                        end
                        CMD_TARGETS:
                        begin
                            next_r.rsp[0] = TGT_RSP_CNT;
                            next_r.rsp[1] = TGT_P;
                            next_r.rsp[2] = TGT_S;
                            next_r.rsp[3] = TGT_I;
                            next_r.rsp[4] = r.stat[0] | r.stat[1] | r.stat[2];
                            next_r.rlen   = 4'h5;
                        end
                        CMD_PRODUCT:
                        begin
                            next_r.rsp[0] = PROD_RSP_CNT;
                            for (int i = 0; i < 11; i++)
                            begin
                                next_r.rsp[i+1] = PRODUCT_CODE[87-8*i -: 8];
                            end
                            next_r.rlen   = 4'hC;
                        end
                        default:
                        begin
                            next_r.rlen = 4'h1;
                        end
                    endcase
                end
            end
            S_ARGS:
            begin
                if (f_valid)
                begin
                    f_pop = 1'b1;
                    if (r.idx != 4'hF)
                    begin
                        next_r.idx = r.idx + 1'b1;
                    end
                    if (f_data[9])
                    begin
                        next_r.st = S_IDLE;
                    end
                    if (r.cmd == CMD_PASSWORD)
                    begin
                        next_r.pw = {r.pw[23:0], b};
                        if (f_data[9])
                        begin
                            next_r.unlocked = (r.idx == 4'h3) && ({r.pw[23:0], b} == PASSWORD);
                        end
                    end
                    else if (r.cmd == CMD_BOOT && r.unlocked)
                    begin
                        if (r.idx == 4'h0)
                        begin
                            next_r.arg0 = b;
                        end
                        else if (r.idx == 4'h1)
                        begin
                            unique case (b)
                                ACT_ENTER:
                                begin
                                    // Target byte not consulted
                                    next_r.in_boot = 1'b1;
                                    for (int i = 0; i < NUM_TGT; i++)
                                    begin
                                        next_r.stat[i] = r.stat[i] | ST_BOOT;
                                    end
                                end
                                ACT_EXIT:
                                begin
                                    for (int i = 0; i < NUM_TGT; i++)
                                    begin
                                        ok = ok && (r.stat[i] == ST_BOOT);
                                    end
                                    if (ok)
                                    begin
                                        next_r.in_boot = 1'b0;
                                        next_r.stat    = '0;
                                    end
                                end
                                ACT_ERASE:
                                begin
                                    if (r.in_boot && t != TGT_NONE)
                                    begin
                                        next_r.tgt  = t;
                                        next_r.walk = '0;
                                        next_r.st   = S_ERASE;
                                    end
                                end
                                ACT_DONE:
                                begin
                                    if (r.in_boot && t != TGT_NONE)
                                    begin
                                        next_r.tgt = t;
                                        if (r.len[t] < (APP_AW+1)'(3))
                                        begin
                                            next_r.stat[t] = r.stat[t] | ST_CRC_BAD;
                                        end
                                        else
                                        begin
                                            next_r.walk = '0;
                                            next_r.crc  = CRC_INIT;
                                            next_r.st   = S_CRC;
                                        end
                                    end
                                end
                                default:
                                begin
                                    for (int i = 0; i < NUM_TGT; i++)
                                    begin
                                        next_r.stat[i] = r.stat[i] | ST_BAD_ACT;
                                    end
                                end
                            endcase
                        end
                    end
                    else if (r.cmd == CMD_DATA && r.unlocked && r.in_boot)
                    begin
                        if (r.idx == 4'h0)
                        begin
                            next_r.arg0 = b;
                        end
                        else if (r.idx == 4'h1)
                        begin
                            if ({b, r.arg0} != r.seq[r.tgt])
                            begin
                                next_r.pkt_bad     = 1'b1;
                                next_r.stat[r.tgt] = r.stat[r.tgt] | ST_SEQ_BAD;
                            end
                        end
                        else if (!r.pkt_bad)
                        begin
                            if (r.len[r.tgt][APP_AW])
                            begin
                                next_r.pkt_bad     = 1'b1;
                                next_r.stat[r.tgt] = r.stat[r.tgt] | ST_RANGE;
                            end
                            else
                            begin
                                mem_we             = 1'b1;
                                mem_a              = {r.tgt, r.len[r.tgt][APP_AW-1:0]};
                                mem_d              = b;
                                next_r.len[r.tgt]  = r.len[r.tgt] + 1'b1;
                            end
                        end
                        if (f_data[9] && r.idx != 4'h0 && !next_r.pkt_bad)
                        begin
                            next_r.seq[r.tgt] = r.seq[r.tgt] + 1'b1;
                        end
                    end
                    else if (r.idx == 4'h0)
                    begin
                        next_r.rtgt = fub_tidx(b);
                    end
                end
            end
            S_ERASE:
            begin
                mem_we      = 1'b1;
                mem_a       = {r.tgt, r.walk};
                mem_d       = ERASED_BYTE;
                next_r.walk = r.walk + 1'b1;
                if (&r.walk)
                begin
                    next_r.st          = S_IDLE;
                    next_r.stat[r.tgt] = ST_BOOT | ST_ERASED;
                    next_r.seq[r.tgt]  = SEQ_FIRST;
                    next_r.len[r.tgt]  = '0;
                end
            end
            S_CRC:
            begin
                next_r.crc  = crc_new;
                next_r.walk = r.walk + 1'b1;
                if (r.walk == APP_AW'(r.len[r.tgt] - 2'd3))
                begin
                    next_r.st          = S_IDLE;
                    next_r.stat[r.tgt] = (crc_new == crc_exp) ? ST_BOOT : (ST_BOOT | ST_CRC_BAD);
                end
            end
            S_SEND:
            begin
                if (OUT_READY)
                begin
                    next_r.rsp  = {8'h00, r.rsp[RSP_MAX-1:1]};
                    next_r.ridx = r.ridx + 1'b1;
                    if (OUT_LAST)
                    begin
                        next_r.st = S_IDLE;
                    end
                end
            end
            default:
            begin
                next_r.st = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            r      <= '0;
            r.st   <= S_IDLE;
            r.stat <= {NUM_TGT{RST_STATUS}};
        end
        else if (CE)
        begin
            r <= next_r;
        end
    end

    always_ff @(posedge CLOCK)
    begin
        if (CE && mem_we)
        begin
            app_mem[mem_a] <= mem_d;
        end
    end
endmodule : fub_top

// [rtl/fub_pkg.sv]
package fub_pkg;
    // Upgrade command codes
    localparam logic [7:0]  CMD_PASSWORD = 8'hE0;
    localparam logic [7:0]  CMD_TARGETS  = 8'hE1;
    localparam logic [7:0]  CMD_APPSTAT  = 8'hE5;
    localparam logic [7:0]  CMD_BOOT     = 8'hE6;
    localparam logic [7:0]  CMD_DATA     = 8'hE7;
    localparam logic [7:0]  CMD_PRODUCT  = 8'hE8;
    // Boot action codes
    localparam logic [7:0]  ACT_ENTER    = 8'h01;
    localparam logic [7:0]  ACT_ERASE    = 8'h02;
    localparam logic [7:0]  ACT_DONE     = 8'h03;
    localparam logic [7:0]  ACT_EXIT     = 8'h04;
    // Status byte encoding
    localparam logic [7:0]  ST_AVAIL     = 8'h00;
    localparam logic [7:0]  ST_ERASED    = 8'h01;
    localparam logic [7:0]  ST_CRC_BAD   = 8'h02;
    localparam logic [7:0]  ST_SEQ_BAD   = 8'h04;
    localparam logic [7:0]  ST_RANGE     = 8'h08;
    localparam logic [7:0]  ST_BAD_ACT   = 8'h10;
    localparam logic [7:0]  ST_DOWNSTRM  = 8'h40;
    localparam logic [7:0]  ST_BOOT      = 8'h80;
    // Target selector characters
    localparam logic [7:0]  TGT_P        = 8'h70;
    localparam logic [7:0]  TGT_S        = 8'h73;
    localparam logic [7:0]  TGT_I        = 8'h69;
    localparam int          NUM_TGT      = 3;
    localparam logic [1:0]  TGT_NONE     = 2'h3;
    // Unlock word, four ASCII characters
    localparam logic [31:0] PASSWORD     = 32'h55504744;
    // CRC-16 and upload
    localparam logic [15:0] CRC_POLY     = 16'h1021;
    localparam logic [15:0] CRC_INIT     = 16'hFFFF;
    localparam logic [7:0]  ERASED_BYTE  = 8'hFF;
    localparam logic [15:0] SEQ_FIRST    = 16'h0000;
    // Read response lengths (count byte excluded, except in RSP_MAX)
    localparam logic [7:0]  SEQ_RSP_CNT  = 8'h03;
    localparam logic [7:0]  TGT_RSP_CNT  = 8'h04;
    localparam logic [7:0]  PROD_RSP_CNT = 8'h0B;
    localparam int          RSP_MAX      = 12;
    // Reset values
    localparam logic [7:0]  RST_STATUS   = 8'h00;
endpackage : fub_pkg

// [sim/fub_sva.sv]
module fub_sva
    import fub_pkg::*;
(
    input wire logic       CLOCK,        // Clock
    input wire logic       ARST_N,       // Async reset
    input wire logic       RD_VALID,     // Read request
    input wire logic       RD_READY,     // Read taken
    input wire logic [7:0] RD_CMD,       // Read command
    input wire logic       OUT_VALID,    // Response valid
    input wire logic       OUT_READY,    // Response taken
    input wire logic [7:0] OUT_DATA,     // Response byte
    input wire logic       OUT_LAST,     // Last byte
    input wire logic       MAIN_OUT_OFF, // Output forced off
    input wire logic       APP_RUN,      // Application running
    input wire logic       UNLOCKED      // Unlocked
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!ARST_N);
    sequence s_take;
        RD_VALID && RD_READY;
    endsequence
    sequence s_hold;
        OUT_VALID && !OUT_READY;
    endsequence
    a_take_answer: assert property (s_take |=> OUT_VALID)
        else $error("no response after read taken");
    a_seq_count: assert property (s_take and RD_CMD == CMD_DATA |=> OUT_DATA == SEQ_RSP_CNT)
        else $error("sequence read count byte wrong");
    a_prod_count: assert property (s_take and RD_CMD == CMD_PRODUCT |=> OUT_DATA == PROD_RSP_CNT)
        else $error("product read count byte wrong");
    a_rd_idle: assert property (RD_READY |-> RD_VALID && !OUT_VALID)
        else $error("read taken while busy");
    a_out_hold: assert property (s_hold |=> OUT_VALID && $stable(OUT_DATA))
        else $error("response byte not held");
    a_out_end: assert property (OUT_VALID && OUT_READY && OUT_LAST |=> !OUT_VALID)
        else $error("response runs past last byte");
    a_last_valid: assert property (OUT_LAST |-> OUT_VALID)
        else $error("last flag without valid");
    a_run_off: assert property (APP_RUN != MAIN_OUT_OFF
        && (!$changed(MAIN_OUT_OFF) || !$past(OUT_VALID)))
        else $error("output off wrong or changed during a read");
    a_boot_lock: assert property ($rose(MAIN_OUT_OFF) |-> UNLOCKED)
        else $error("boot entered while locked");
    a_exit_lock: assert property ($fell(MAIN_OUT_OFF) |-> UNLOCKED)
        else $error("boot left while locked");
endmodule : fub_sva

// [sim/fub_host.sv]
module fub_host
    import fub_pkg::*;
(
    input  wire logic       clk,       // Clock
    input  wire logic       in_ready,  // Write accepted
    output      logic       in_valid,  // Write valid
    output      logic [7:0] in_data,   // Write byte
    output      logic       in_first,  // Command byte
    output      logic       in_last,   // Final byte
    input  wire logic       rd_ready,  // Read taken
    output      logic       rd_valid,  // Read request
    output      logic [7:0] rd_cmd,    // Read command
    input  wire logic       out_valid, // Response valid
    output      logic       out_ready, // Response taken
    input  wire logic [7:0] out_data,  // Response byte
    input  wire logic       out_last   // Last byte
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] wq[$];
    logic [7:0] rq[$];
    logic       stall = 1'b0;
    initial
    begin
        {in_valid, in_data, in_first, in_last, rd_valid, rd_cmd, out_ready} = '0;
    end
    // Whole command, held until taken; one target at a time from the bench
    task send();
        for (int i = 0; i < wq.size(); i++)
        begin
            in_valid <= 1'b1;
            in_data  <= wq[i];
            in_first <= (i == 0);
            in_last  <= (i == wq.size() - 1);
            @(posedge clk);
            while (in_ready !== 1'b1)
            begin
                stall = 1'b1;
                @(posedge clk);
            end
        end
        in_valid <= 1'b0;
        in_data  <= ~in_data;
        wq.delete();
        @(posedge clk);
    endtask : send
    // Response taken with alternating stalls
    task rd(input logic [7:0] c);
        int k;
        k = 0;
        rq.delete();
        rd_valid <= 1'b1;
        rd_cmd   <= c;
        do @(posedge clk); while (rd_ready !== 1'b1);
        rd_valid <= 1'b0;
        rd_cmd   <= ~c;
        while (k < 60)
        begin
            @(posedge clk);
            k++;
            if (out_valid === 1'b1 && out_ready === 1'b1)
            begin
                rq.push_back(out_data);
                if (out_last === 1'b1)
                    k = 99;
            end
            out_ready <= k[0] && k < 60;
        end
        @(posedge clk);
    endtask : rd
endmodule : fub_host

// [sim/tb_firmware_upgrade_bootloader.sv]
module tb_firmware_upgrade_bootloader
    import fub_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [87:0] PCODE = 88'h4142434445464748494A4B; // Arbitrary value
    logic       CLOCK = 1'b0, ARST_N = 1'b0, CE = 1'b1;
    logic       IN_VALID, IN_READY, IN_FIRST, IN_LAST, RD_VALID, RD_READY, OUT_VALID, OUT_READY, OUT_LAST;
    logic [7:0] IN_DATA, RD_CMD, OUT_DATA;
    logic       MAIN_OUT_OFF, APP_RUN, UNLOCKED;
    int         failures = 0, n_checks = 0, cyc = 0, seed = 40;
    logic [7:0] app[8];
    logic [15:0] crc;
    always #25 CLOCK = ~CLOCK;
    fub_top #(.APP_AW(8), .FIFO_DEPTH(32), .PRODUCT_CODE(PCODE)) u_dut (.CLOCK, .ARST_N, .CE, .IN_VALID,
        .IN_READY, .IN_DATA, .IN_FIRST, .IN_LAST, .RD_VALID, .RD_READY, .RD_CMD, .OUT_VALID, .OUT_READY,
        .OUT_DATA, .OUT_LAST, .MAIN_OUT_OFF, .APP_RUN, .UNLOCKED);
    fub_host u_host (.clk(CLOCK), .in_ready(IN_READY), .in_valid(IN_VALID), .in_data(IN_DATA),
        .in_first(IN_FIRST), .in_last(IN_LAST), .rd_ready(RD_READY), .rd_valid(RD_VALID), .rd_cmd(RD_CMD),
        .out_valid(OUT_VALID), .out_ready(OUT_READY), .out_data(OUT_DATA), .out_last(OUT_LAST));
    task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task tally_and_finish();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish
    function automatic logic [15:0] crc16(input int n);
        logic [15:0] c = CRC_INIT;
        for (int i = 0; i < n; i++)
        begin
            c = c ^ {app[i], 8'h00};
            for (int b = 0; b < 8; b++)
                c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        return c;
    endfunction : crc16
    // Host waits well past the device's work after every action
    task boot(input logic [7:0] t, input logic [7:0] a);
        u_host.wq = {CMD_BOOT, t, a};
        u_host.send();
        repeat (400) @(posedge CLOCK);
    endtask : boot
    task st(input logic [7:0] t);
        u_host.wq = {CMD_APPSTAT, t};
        u_host.send();
        u_host.rd(CMD_APPSTAT);
    endtask : st
    always @(posedge CLOCK)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            failures++;
            tally_and_finish();
        end
    end
    initial
    begin
        repeat (16) @(posedge CLOCK);
        ARST_N <= 1'b1;
        @(posedge CLOCK);
        chk("run", APP_RUN, 1);
        boot(8'h00, ACT_ENTER);
        chk("locked", MAIN_OUT_OFF, 0);
        u_host.wq = {CMD_PASSWORD, PASSWORD[31:24], PASSWORD[23:16], PASSWORD[15:8], PASSWORD[7:0]};
        u_host.send();
        repeat (8) @(posedge CLOCK);
        chk("unlock", UNLOCKED, 1);
        u_host.rd(CMD_PRODUCT);
        chk("plen", u_host.rq.size(), 12);
        for (int i = 0; i < 11; i++)
            chk("pcode", u_host.rq[i+1], PCODE[87-8*i -: 8]);
        boot(8'h55, ACT_ENTER);
        chk("off", MAIN_OUT_OFF, 1);
        boot(TGT_P, ACT_ERASE);
        st(TGT_P);
        chk("erased", u_host.rq[0], ST_BOOT | ST_ERASED);
        boot(8'h00, ACT_EXIT);
        chk("noexit", APP_RUN, 0);
        u_host.wq = {CMD_DATA, 8'h05, 8'h00, 8'h11, 8'h22};
        u_host.send();
        u_host.rd(CMD_DATA);
        chk("badseq", u_host.rq[3], ST_BOOT | ST_ERASED | ST_SEQ_BAD);
        chk("seqlo", u_host.rq[1], SEQ_FIRST[7:0]);
        crc = {8'h00, u_host.rq[3]};
        st(TGT_P);
        chk("same", u_host.rq[0], crc);
        u_host.wq = {CMD_BOOT, TGT_P, ACT_ERASE};
        u_host.send();
        u_host.stall = 1'b0;
        u_host.wq = {CMD_TARGETS};
        repeat (32) u_host.wq.push_back(TGT_P);
        u_host.send();
        chk("full", u_host.stall, 1);
        repeat (400) @(posedge CLOCK);
        for (int i = 0; i < 6; i++)
            app[i] = $random(seed);
        crc = crc16(6);
        app[6] = crc[15:8];
        app[7] = crc[7:0];
        for (int p = 0; p < 2; p++)
        begin
            u_host.wq = {CMD_DATA, 8'(p), 8'h00};
            for (int j = 0; j < 4; j++)
                u_host.wq.push_back(app[4*p+j]);
            u_host.send();
            u_host.rd(CMD_DATA);
            chk("cnt", u_host.rq[0], SEQ_RSP_CNT);
            chk("seq", {u_host.rq[2], u_host.rq[1]}, 16'(p + 1));
            chk("stat", u_host.rq[3], ST_BOOT | ST_ERASED);
        end
        boot(TGT_P, ACT_DONE);
        st(TGT_P);
        chk("crc", u_host.rq[0], ST_BOOT);
        boot(8'h33, ACT_EXIT);
        chk("exit", APP_RUN, 1);
        u_host.rd(CMD_TARGETS);
        crc = 16'(u_host.rq.size());
        chk("tlen", crc, 5);
        chk("tlst", u_host.rq[4], ST_AVAIL);
        boot(8'h00, ACT_ENTER);
        boot(TGT_S, 8'h07);
        st(TGT_S);
        chk("badact", u_host.rq[0], ST_BOOT | ST_BAD_ACT);
        tally_and_finish();
    end
endmodule : tb_firmware_upgrade_bootloader
bind fub_top fub_sva u_sva (.CLOCK(CLOCK), .ARST_N(ARST_N), .RD_VALID(RD_VALID), .RD_READY(RD_READY),
    .RD_CMD(RD_CMD), .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY), .OUT_DATA(OUT_DATA), .OUT_LAST(OUT_LAST),
    .MAIN_OUT_OFF(MAIN_OUT_OFF), .APP_RUN(APP_RUN), .UNLOCKED(UNLOCKED));
